// >>> core_access_pkg.sv
// constants and types shared by the indirect core access engine
package core_access_pkg;
  // ==========================================================
  // register offsets on the host port
  localparam logic [9:0] OFS_RD_PORT_LO = 10'h000;
  localparam logic [9:0] OFS_RD_PORT_HI = 10'h01C;
  localparam logic [9:0] OFS_WR_PORT_LO = 10'h020;
  localparam logic [9:0] OFS_WR_PORT_HI = 10'h03C;
  localparam logic [9:0] OFS_CORE_DATA = 10'h300;
  localparam logic [9:0] OFS_CORE_CMD = 10'h304;
  localparam logic [9:0] OFS_RD_ADDR_LEN = 10'h308;
  localparam logic [9:0] OFS_RD_CMD = 10'h30C;
  localparam logic [9:0] OFS_WR_ADDR_LEN = 10'h310;
  localparam logic [9:0] OFS_WR_CMD = 10'h314;

  // ==========================================================
  // field positions
  localparam int BIT_BUSY = 31;
  localparam int BIT_DIR = 30;
  localparam int BIT_ABORT = 30;
  localparam int SIZE_LSB = 16;
  localparam int SIZE_MSB = 18;
  localparam int LEN_LSB = 16;
  localparam int CNT_LSB = 8;
  localparam int CNT_MSB = 12;
  localparam int FLAG_BIT = 0;

  // ==========================================================
  // sizes and reset values
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] SPACE_FULL = 5'h10;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [2:0] SIZE_RST = 3'h0;

  // ==========================================================
  // core port sequencer states, gray-coded in the order idle, core, read, write
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CORE = 2'h1,
    ST_RD = 2'h3,
    ST_WR = 2'h2
  } eng_state_t;
endpackage : core_access_pkg

// >>> data_fifo.sv
// synchronous word fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic mclk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic flush_in, // empties the fifo
  input wire logic in_valid_in, // write side offers a word
  output logic in_ready_out, // not full
  input wire logic [WIDTH-1:0] in_data_in, // word to store
  output logic out_valid_out, // not empty
  input wire logic out_ready_in, // read side takes the head
  output logic [WIDTH-1:0] out_data_out, // head word
  output logic [AW:0] level_out // words held
);
  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] level_r;
  logic push;
  logic pop;

  // full and empty straight from the level
  assign in_ready_out = (level_r != (AW + 1)'(DEPTH));
  assign out_valid_out = (level_r != '0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;
  assign out_data_out = mem_r[rd_ptr_r];
  assign level_out = level_r;

  // storage array, no reset needed
  always_ff @(posedge mclk_in)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_in;
  end

  // pointers and level, flush wins over traffic
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= '0;
    end
    else if (flush_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= '0;
    end
    else
    begin
      wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      case ({push, pop})
        2'h2: level_r <= level_r + (AW + 1)'(1);
        2'h1: level_r <= level_r - (AW + 1)'(1);
        default: level_r <= level_r;
      endcase
    end
  end
endmodule : data_fifo

// >>> indirect_core_access_engine.sv
// indirect core register access and process ram burst engine
//
// Functional notes
// [RULE1] busy write of one starts one core access
// [RULE2] busy holds during access, clears when done
// [RULE3] host leaves command and data alone while busy
// [RULE4] direction zero writes, direction one reads
// [RULE5] host programs size one, two or four
// [RULE6] core address field is a byte address
// [RULE7] host aligns core accesses to their size
// [RULE8] bursts stay inside ram window 1000h-2FFFh
// [RULE9] read length decrements as bytes are fetched
// [RULE10] read address increments as bytes are fetched
// [RULE11] host leaves read address/length alone while busy
// [RULE12] read busy starts burst, self-clears at end
// [RULE13] read abort cancels burst, flushes fifo, self-clears
// [RULE14] read word count tracks fifo fill, resets zero
// [RULE15] read data flag set while fifo holds data
// [RULE16] write length decrements, address increments on drain
// [RULE17] host leaves write address/length alone while busy
// [RULE18] write busy starts burst, self-clears at end
// [RULE19] write abort cancels burst, flushes fifo, self-clears
// [RULE20] write space count resets sixteen, tracks fifo
// [RULE21] write space flag set while fifo not full
// [RULE22] data register reads core value or last write
// [RULE23] data sits low, engine aligns byte lanes
// [RULE24] host reads read port only with data flagged
// [RULE25] fifo ports answer over their address ranges
// [RULE26] empty reads and full writes change nothing
// [RULE27] partial last word carries don't-care lanes
`timescale 1ns/1ps
module indirect_core_access_engine (
  input wire logic mclk_in, // system clock, 100 MHz
  input wire logic rst_n_in, // async reset, active low
  input wire logic [9:0] host_addr_in, // host register byte address
  input wire logic host_wr_in, // host write strobe, one cycle
  input wire logic host_rd_in, // host read strobe, one cycle
  input wire logic [31:0] host_wdata_in, // host write data
  output logic [31:0] host_rdata_out, // read data, cycle after strobe
  output logic core_req_out, // core access request, held to ack
  output logic core_we_out, // core access is a write
  output logic [15:0] core_addr_out, // core word-aligned byte address
  output logic [3:0] core_be_out, // core byte lane enables
  output logic [31:0] core_wdata_out, // core write data on its lanes
  input wire logic core_ack_in, // core access done
  input wire logic [31:0] core_rdata_in // core read data on its lanes
);
  // ==========================================================
  // helpers
  // bytes mask for a count of one to four bytes
  function automatic logic [3:0] lane_mask(input logic [2:0] n);
    case (n)
      3'h1: lane_mask = 4'h1;
      3'h2: lane_mask = 4'h3;
      3'h3: lane_mask = 4'h7;
      3'h4: lane_mask = 4'hF;
      default: lane_mask = 4'h0;
    endcase
  endfunction : lane_mask

  // bytes that fit before the next word boundary
  function automatic logic [2:0] chunk_of(input logic [1:0] lo, input logic [15:0] len);
    logic [2:0] room;
    room = 3'h4 - {1'b0, lo};
    chunk_of = (len < {13'h0000, room}) ? len[2:0] : room;
  endfunction : chunk_of

  // ==========================================================
  // state
  core_access_pkg::eng_state_t state_r, state_nxt;
  logic core_busy_r, core_busy_nxt;
  logic dir_r;
  logic [2:0] size_r;
  logic [15:0] caddr_r;
  logic [31:0] cdata_wr_r, cdata_rd_r;
  logic [15:0] rd_len_r, rd_len_nxt, rd_addr_r, rd_addr_nxt;
  logic [15:0] wr_len_r, wr_len_nxt, wr_addr_r, wr_addr_nxt;
  logic rd_busy_r, rd_busy_nxt, rd_abort_r;
  logic wr_busy_r, wr_busy_nxt, wr_abort_r;
  logic [1:0] lane_r;
  logic [2:0] n_r;
  logic [15:0] core_addr_r;
  logic [3:0] core_be_r;
  logic core_we_r;
  logic [31:0] core_wdata_r;
  logic [31:0] rdata_r, rdata_nxt;

  // ==========================================================
  // host decode
  logic hit_rd_port, hit_wr_port;
  logic wr_data, wr_cmd, wr_rd_al, wr_rd_cmd, wr_wr_al, wr_wr_cmd;
  logic rd_start, rd_abort_set, wr_start, wr_abort_set;
  // [RULE25] fifo ports over ranges
  assign hit_rd_port = (host_addr_in <= core_access_pkg::OFS_RD_PORT_HI);
  assign hit_wr_port = (host_addr_in >= core_access_pkg::OFS_WR_PORT_LO) &&
                       (host_addr_in <= core_access_pkg::OFS_WR_PORT_HI);
  assign wr_data = host_wr_in && host_addr_in == core_access_pkg::OFS_CORE_DATA;
  assign wr_cmd = host_wr_in && host_addr_in == core_access_pkg::OFS_CORE_CMD;
  assign wr_rd_al = host_wr_in && host_addr_in == core_access_pkg::OFS_RD_ADDR_LEN;
  assign wr_rd_cmd = host_wr_in && host_addr_in == core_access_pkg::OFS_RD_CMD;
  assign wr_wr_al = host_wr_in && host_addr_in == core_access_pkg::OFS_WR_ADDR_LEN;
  assign wr_wr_cmd = host_wr_in && host_addr_in == core_access_pkg::OFS_WR_CMD;
  assign rd_start = wr_rd_cmd && host_wdata_in[core_access_pkg::BIT_BUSY];
  assign rd_abort_set = wr_rd_cmd && host_wdata_in[core_access_pkg::BIT_ABORT];
  assign wr_start = wr_wr_cmd && host_wdata_in[core_access_pkg::BIT_BUSY];
  assign wr_abort_set = wr_wr_cmd && host_wdata_in[core_access_pkg::BIT_ABORT];

  // ==========================================================
  // fifos
  logic rf_push, rf_ready, rf_valid, rf_pop;
  logic wf_push, wf_ready, wf_valid, wf_pop;
  logic [31:0] rf_data, wf_data, rf_in_data;
  logic [4:0] rf_level, wf_level, wr_space;
  // [RULE26] empty reads and full writes refused by the fifo
  assign rf_pop = host_rd_in && hit_rd_port;
  assign wf_push = host_wr_in && hit_wr_port;
  // [RULE27] unused lanes of a partial word left as fetched
  assign rf_in_data = core_rdata_in >> {lane_r, 3'h0};
  assign rf_push = (state_r == core_access_pkg::ST_RD) && core_ack_in && rd_busy_r;
  assign wf_pop = (state_r == core_access_pkg::ST_WR) && core_ack_in && wr_busy_r;
  // [RULE20] space counts down from sixteen as the fifo fills
  assign wr_space = core_access_pkg::SPACE_FULL - wf_level;

  // read fifo, flushed by the read abort pulse
  data_fifo #(
    .WIDTH(core_access_pkg::FIFO_WIDTH),
    .DEPTH(core_access_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .flush_in(rd_abort_r),
    .in_valid_in(rf_push),
    .in_ready_out(rf_ready),
    .in_data_in(rf_in_data),
    .out_valid_out(rf_valid),
    .out_ready_in(rf_pop),
    .out_data_out(rf_data),
    .level_out(rf_level)
  );

  // write fifo, flushed by the write abort pulse
  data_fifo #(
    .WIDTH(core_access_pkg::FIFO_WIDTH),
    .DEPTH(core_access_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .flush_in(wr_abort_r),
    .in_valid_in(wf_push),
    .in_ready_out(wf_ready),
    .in_data_in(host_wdata_in),
    .out_valid_out(wf_valid),
    .out_ready_in(wf_pop),
    .out_data_out(wf_data),
    .level_out(wf_level)
  );

  // ==========================================================
  // core port sequencer
  logic go_core, go_rd, go_wr, ack_core, rd_step, wr_step;
  logic [2:0] rd_n, wr_n;
  // a read chunk waits for fifo room, a write chunk for fifo data
  assign go_core = core_busy_r;
  assign go_rd = rd_busy_r && rd_len_r != '0 && rf_ready;
  assign go_wr = wr_busy_r && wr_len_r != '0 && wf_valid;
  assign rd_n = chunk_of(rd_addr_r[1:0], rd_len_r);
  assign wr_n = chunk_of(wr_addr_r[1:0], wr_len_r);
  assign ack_core = (state_r == core_access_pkg::ST_CORE) && core_ack_in;
  assign rd_step = rf_push;
  assign wr_step = wf_pop;

  // next state: one access at a time, command first
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      core_access_pkg::ST_IDLE:
        if (go_core)
          state_nxt = core_access_pkg::ST_CORE;
        else if (go_rd)
          state_nxt = core_access_pkg::ST_RD;
        else if (go_wr)
          state_nxt = core_access_pkg::ST_WR;
      core_access_pkg::ST_CORE, core_access_pkg::ST_RD, core_access_pkg::ST_WR:
        if (core_ack_in)
          state_nxt = core_access_pkg::ST_IDLE;
      default: state_nxt = core_access_pkg::ST_IDLE;
    endcase
  end

  // launch values for the access about to start
  logic [1:0] l_lane;
  logic [2:0] l_n;
  logic [15:0] l_addr;
  logic [31:0] l_wdata;
  // [RULE6] [RULE23] byte address split into word and lanes
  assign l_lane = go_core ? caddr_r[1:0] : go_rd ? rd_addr_r[1:0] : wr_addr_r[1:0];
  assign l_n = go_core ? size_r : go_rd ? rd_n : wr_n;
  assign l_addr = go_core ? caddr_r : go_rd ? rd_addr_r : wr_addr_r;
  assign l_wdata = go_core ? cdata_wr_r : wf_data;

  // core port registers
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= core_access_pkg::ST_IDLE;
      lane_r <= 2'h0;
      n_r <= 3'h0;
      core_addr_r <= core_access_pkg::HALF_RST;
      core_be_r <= 4'h0;
      core_we_r <= 1'b0;
      core_wdata_r <= core_access_pkg::DATA_RST;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == core_access_pkg::ST_IDLE)
      begin
        lane_r <= l_lane;
        n_r <= l_n;
        core_addr_r <= {l_addr[15:2], 2'h0};
        core_be_r <= 4'(lane_mask(l_n) << l_lane);
        // [RULE4] direction zero is a write
        core_we_r <= go_core ? !dir_r : !go_rd;
        core_wdata_r <= l_wdata << {l_lane, 3'h0};
      end
    end
  end

  assign core_req_out = (state_r != core_access_pkg::ST_IDLE);
  assign core_we_out = core_we_r;
  assign core_addr_out = core_addr_r;
  assign core_be_out = core_be_r;
  assign core_wdata_out = core_wdata_r;

  // ==========================================================
  // busy, address and length next values
  // [RULE1] [RULE2] set by a one, cleared by the ack
  assign core_busy_nxt = (wr_cmd && host_wdata_in[core_access_pkg::BIT_BUSY]) ? 1'b1 :
                         ack_core ? 1'b0 : core_busy_r;
  // [RULE12] [RULE13] abort beats start, clears when length runs out
  assign rd_busy_nxt = rd_abort_set ? 1'b0 : rd_start ? 1'b1 :
                       (rd_len_r == '0 && state_r != core_access_pkg::ST_RD) ? 1'b0 :
                       rd_busy_r;
  // [RULE18] [RULE19] same scheme for the write burst
  assign wr_busy_nxt = wr_abort_set ? 1'b0 : wr_start ? 1'b1 :
                       (wr_len_r == '0 && state_r != core_access_pkg::ST_WR) ? 1'b0 :
                       wr_busy_r;
  // [RULE9] [RULE10] step read window per fetched chunk
  assign rd_len_nxt = wr_rd_al ? host_wdata_in[31:core_access_pkg::LEN_LSB] :
                      rd_step ? rd_len_r - {13'h0000, n_r} : rd_len_r;
  assign rd_addr_nxt = wr_rd_al ? host_wdata_in[15:0] :
                       rd_step ? rd_addr_r + {13'h0000, n_r} : rd_addr_r;
  // [RULE16] step write window per drained chunk
  assign wr_len_nxt = wr_wr_al ? host_wdata_in[31:core_access_pkg::LEN_LSB] :
                      wr_step ? wr_len_r - {13'h0000, n_r} : wr_len_r;
  assign wr_addr_nxt = wr_wr_al ? host_wdata_in[15:0] :
                       wr_step ? wr_addr_r + {13'h0000, n_r} : wr_addr_r;

  // read data lanes kept for the core value, sized to the access
  logic [3:0] size_lanes;
  logic [31:0] size_bits;
  assign size_lanes = lane_mask(n_r);
  assign size_bits = {{8{size_lanes[3]}}, {8{size_lanes[2]}}, {8{size_lanes[1]}},
                      {8{size_lanes[0]}}};

  // control registers
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      core_busy_r <= 1'b0;
      dir_r <= 1'b0;
      size_r <= core_access_pkg::SIZE_RST;
      caddr_r <= core_access_pkg::HALF_RST;
      cdata_wr_r <= core_access_pkg::DATA_RST;
      cdata_rd_r <= core_access_pkg::DATA_RST;
      rd_len_r <= core_access_pkg::HALF_RST;
      rd_addr_r <= core_access_pkg::HALF_RST;
      wr_len_r <= core_access_pkg::HALF_RST;
      wr_addr_r <= core_access_pkg::HALF_RST;
      rd_busy_r <= 1'b0;
      wr_busy_r <= 1'b0;
      rd_abort_r <= 1'b0;
      wr_abort_r <= 1'b0;
      rdata_r <= core_access_pkg::DATA_RST;
    end
    else
    begin
      core_busy_r <= core_busy_nxt;
      if (wr_cmd)
      begin
        dir_r <= host_wdata_in[core_access_pkg::BIT_DIR];
        size_r <= host_wdata_in[core_access_pkg::SIZE_MSB:core_access_pkg::SIZE_LSB];
        caddr_r <= host_wdata_in[15:0];
      end
      if (wr_data)
        cdata_wr_r <= host_wdata_in;
      // [RULE23] core value moved down to the low lanes
      if (ack_core && dir_r)
        cdata_rd_r <= (core_rdata_in >> {lane_r, 3'h0}) & size_bits;
      rd_len_r <= rd_len_nxt;
      rd_addr_r <= rd_addr_nxt;
      wr_len_r <= wr_len_nxt;
      wr_addr_r <= wr_addr_nxt;
      rd_busy_r <= rd_busy_nxt;
      wr_busy_r <= wr_busy_nxt;
      // [RULE13] [RULE19] abort shows for one cycle, flushes the fifo
      rd_abort_r <= rd_abort_set;
      wr_abort_r <= wr_abort_set;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // host read mux, unmapped reads return zero
  always_comb
  begin
    rdata_nxt = core_access_pkg::DATA_RST;
    if (host_rd_in)
    begin
      if (hit_rd_port)
        rdata_nxt = rf_valid ? rf_data : core_access_pkg::DATA_RST;
      else
        case (host_addr_in)
          // [RULE22] core value when reading, else last write
          core_access_pkg::OFS_CORE_DATA: rdata_nxt = dir_r ? cdata_rd_r : cdata_wr_r;
          core_access_pkg::OFS_CORE_CMD:
            rdata_nxt = {core_busy_r, dir_r, 10'h000, 1'b0, size_r, caddr_r};
          core_access_pkg::OFS_RD_ADDR_LEN: rdata_nxt = {rd_len_r, rd_addr_r};
          // [RULE14] [RULE15] fifo fill and data flag
          core_access_pkg::OFS_RD_CMD:
            rdata_nxt = {rd_busy_r, rd_abort_r, 17'h0_0000, rf_level, 7'h00, rf_valid};
          core_access_pkg::OFS_WR_ADDR_LEN: rdata_nxt = {wr_len_r, wr_addr_r};
          // [RULE20] [RULE21] space count and space flag
          core_access_pkg::OFS_WR_CMD:
            rdata_nxt = {wr_busy_r, wr_abort_r, 17'h0_0000, wr_space, 7'h00, wf_ready};
          default: rdata_nxt = core_access_pkg::DATA_RST;
        endcase
    end
  end

  assign host_rdata_out = rdata_r;

  // ==========================================================
  // checks
  chk_core_start: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE1]
    (wr_cmd && host_wdata_in[31] && state_r == core_access_pkg::ST_IDLE
      && !core_busy_r && !go_rd && !go_wr)
      |=> core_busy_r ##1 (state_r == core_access_pkg::ST_CORE))
    else $error("core access did not start");
  chk_core_done: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE2]
    ack_core |=> !core_busy_r && state_r == core_access_pkg::ST_IDLE)
    else $error("core busy did not clear on ack");
  chk_core_dir: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE4]
    (state_r == core_access_pkg::ST_CORE) |-> (core_we_out == !dir_r))
    else $error("core access direction wrong");
  chk_core_lanes: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE6]
    (state_r == core_access_pkg::ST_CORE && size_r == 3'h1)
      |-> core_be_out == 4'(4'h1 << caddr_r[1:0]) && core_addr_out[15:2] == caddr_r[15:2])
    else $error("core byte address not honoured");
  chk_rd_step: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE10]
    (rf_push && !wr_rd_al) |=> rd_addr_r == $past(rd_addr_r) + {13'h0000, $past(n_r)}
      && rd_len_r == $past(rd_len_r) - {13'h0000, $past(n_r)})
    else $error("read window did not step");
  chk_rd_abort: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE13]
    rd_abort_set |=> !rd_busy_r && rd_abort_r ##1 !rd_abort_r && rf_level == '0)
    else $error("read abort incomplete");
  chk_wr_step: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE16]
    (wf_pop && !wr_wr_al) |=> wr_addr_r == $past(wr_addr_r) + {13'h0000, $past(n_r)})
    else $error("write address did not step");
  chk_wr_abort: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE19]
    wr_abort_set |=> !wr_busy_r ##1 wr_space == core_access_pkg::SPACE_FULL)
    else $error("write abort incomplete");
  chk_empty_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE26]
    (rf_pop && !rf_valid && !rf_push && !rd_abort_r) |=> rf_level == '0)
    else $error("empty read changed the fifo");
  chk_rd_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE15]
    (host_rd_in && host_addr_in == core_access_pkg::OFS_RD_CMD)
      |=> host_rdata_out[0] == ($past(rf_level) != '0))
    else $error("read data flag disagrees with count");
endmodule : indirect_core_access_engine

// >>> core_model.sv
// core side model: byte-lane memory answering the engine's requests
`timescale 1ns/1ps
module core_model (
  input wire logic mclk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic slow_in, // late acks
  input wire logic req_in, // access request
  input wire logic we_in, // write access
  input wire logic [15:0] addr_in, // word aligned address
  input wire logic [3:0] be_in, // byte lanes
  input wire logic [31:0] wdata_in, // write data
  output logic ack_out, // access done pulse
  output logic [31:0] rdata_out // read data
);
  logic [31:0] mem [logic [13:0]];
  int wait_cnt;
  // ==========
  // one ack per request; data inverts each cycle it is not valid
  always @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      ack_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      wait_cnt <= 0;
    end
    else
    begin
      rdata_out <= ~rdata_out;
      ack_out <= 1'b0;
      if (req_in && !ack_out && wait_cnt >= (slow_in ? 3 : 0))
      begin
        wait_cnt <= 0;
        ack_out <= 1'b1;
        if (!mem.exists(addr_in[15:2]))
          mem[addr_in[15:2]] = {~addr_in, addr_in};
        for (int i = 0; i < 4; i++)
          if (we_in && be_in[i])
            mem[addr_in[15:2]][8*i+:8] = wdata_in[8*i+:8];
        rdata_out <= mem[addr_in[15:2]];
      end
      else if (req_in && !ack_out)
        wait_cnt <= wait_cnt + 1;
    end
endmodule : core_model

// >>> test_indirect_core_access_engine.sv
// self-checking bench for the indirect core access engine
`timescale 1ns/1ps
module test_indirect_core_access_engine;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [9:0] host_addr_in = 10'h000;
  logic host_wr_in = 1'b0;
  logic host_rd_in = 1'b0;
  logic [31:0] host_wdata_in = 32'h0000_0000;
  logic [31:0] host_rdata_out, core_wdata_out, core_rdata_in, v;
  logic core_req_out, core_we_out, core_ack_in;
  logic slow = 1'b0;
  logic [15:0] core_addr_out;
  logic [3:0] core_be_out;
  int errors = 0;
  int total_checks = 0;
  typedef struct {bit w; logic [9:0] a; logic [31:0] d;} row_t;
  // rows: write flag, address, data written or value expected
  row_t rows [15] = '{'{0, 10'h304, 0}, '{0, 10'h308, 0}, '{0, 10'h30C, 0},
    '{0, 10'h310, 0}, '{0, 10'h314, 32'h0000_1001}, '{0, 10'h300, 0}, '{0, 10'h000, 0},
    '{1, 10'h308, 32'h0004_1000}, '{0, 10'h308, 32'h0004_1000}, '{1, 10'h300, 32'hCAFE_F00D},
    '{0, 10'h300, 32'hCAFE_F00D}, '{1, 10'h304, 32'h0004_0010}, '{0, 10'h304, 32'h0004_0010},
    '{1, 10'h1F0, 32'hFFFF_FFFF}, '{0, 10'h1F0, 0}};
  // legal sizes, aligned addresses
  // core commands: data register value, command, data expected after
  logic [31:0] cmds [6][3] = '{'{32'h1234_5678, 32'h8004_0200, 32'h1234_5678},
    '{0, 32'hC004_0200, 32'h1234_5678}, '{32'h0000_00AB, 32'h8001_0201, 32'h0000_00AB},
    '{0, 32'hC004_0200, 32'h1234_AB78}, '{0, 32'hC001_0102, 32'h0000_00FF},
    '{0, 32'hC002_0122, 32'h0000_FEDF}};

  indirect_core_access_engine i_indirect_core_access_engine (.mclk_in, .rst_n_in,
    .host_addr_in, .host_wr_in, .host_rd_in, .host_wdata_in, .host_rdata_out, .core_req_out,
    .core_we_out, .core_addr_out, .core_be_out, .core_wdata_out, .core_ack_in, .core_rdata_in);
  core_model i_core_model (.mclk_in, .rst_n_in, .slow_in(slow), .req_in(core_req_out),
    .we_in(core_we_out), .addr_in(core_addr_out), .be_in(core_be_out),
    .wdata_in(core_wdata_out), .ack_out(core_ack_in), .rdata_out(core_rdata_in));

  // ==========
  // host port tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic hw(input logic [9:0] a, input logic [31:0] d);
    @(negedge mclk_in);
    host_addr_in = a;
    host_wdata_in = d;
    host_wr_in = 1'b1;
    @(negedge mclk_in);
    host_wr_in = 1'b0;
  endtask : hw
  task automatic hr(input logic [9:0] a);
    @(negedge mclk_in);
    host_addr_in = a;
    host_rd_in = 1'b1;
    @(negedge mclk_in);
    host_rd_in = 1'b0;
    v = host_rdata_out;
  endtask : hr
  // poll a register until the masked bits match, bounded
  task automatic poll(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 300; i++)
    begin
      hr(a);
      if ((v & m) === e) return;
    end
    chk("poll", v & m, e);
  endtask : poll
  task automatic cmd(input int r);
    hw(10'h300, cmds[r][0]);
    hw(10'h304, cmds[r][1]);
    hr(10'h304);
    chk("cmd busy", 32'(v[31]), 32'h0000_0001);
    poll(10'h304, 32'h8000_0000, 0);
    hr(10'h300);
    chk("cmd data", v, cmds[r][2]);
  endtask : cmd
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  always #5 mclk_in = ~mclk_in;
  // watchdog
  initial
  begin
    #200_000;
    errors++;
    close_out();
  end
  // ==========
  // main sequence
  initial
  begin
    logic [15:0] w;
    repeat (5) @(negedge mclk_in);
    rst_n_in = 1'b1;
    foreach (rows[i])
      if (rows[i].w) hw(rows[i].a, rows[i].d);
      else
      begin
        hr(rows[i].a);
        chk($sformatf("reg %h", rows[i].a), v, rows[i].d);
      end
    slow = 1'b1;
    for (int r = 0; r < 6; r++) cmd(r);
    // read burst fills the fifo, then drains
    // window in ram, held while busy
    slow = 1'b0;
    hw(10'h308, 32'h0044_1000);
    hw(10'h30C, 32'h8000_0000);
    poll(10'h30C, 32'h0000_1F00, 32'h0000_1000);
    hr(10'h30C);
    chk("rd full", v, 32'h8000_1001);
    // port read only with data flagged
    for (int i = 0; i < 17; i++)
    begin
      hr(10'(4 * (i % 8)));
      w = 16'h1000 + 16'(4 * i);
      chk("rd word", v, {~w, w});
    end
    hr(10'h30C);
    chk("rd done", v, 0);
    hr(10'h308);
    chk("rd window", v, 32'h0000_1044);
    hr(10'h000);
    chk("rd empty", v, 0);
    slow = 1'b1;
    hw(10'h308, 32'h0006_1001);
    hw(10'h30C, 32'h8000_0000);
    poll(10'h30C, 32'h8000_0000, 0);
    hr(10'h30C);
    chk("rd part", v, 32'h0000_0201);
    hr(10'h004);
    chk("part 0", v & 32'h00FF_FFFF, 32'h00EF_FF10);
    hr(10'h01C);
    chk("part 1", v & 32'h00FF_FFFF, 32'h00FB_1004);
    hw(10'h308, 32'h0044_1000);
    hw(10'h30C, 32'h8000_0000);
    hw(10'h30C, 32'h4000_0000);
    hr(10'h30C);
    chk("rd abort", v, 0);
    // write burst: fill until refused, then drain to the core
    slow = 1'b0;
    for (int i = 0; i < 17; i++) hw(10'h020 + 10'(4 * (i % 8)), 32'h5A00_0000 + i);
    hr(10'h314);
    chk("wr full", v, 0);
    // window in ram, held while busy
    hw(10'h310, 32'h0040_2000);
    hw(10'h314, 32'h8000_0000);
    poll(10'h314, 32'h8000_0000, 0);
    hr(10'h314);
    chk("wr done", v, 32'h0000_1001);
    hr(10'h310);
    chk("wr window", v, 32'h0000_2040);
    cmds[0] = '{0, 32'hC004_2000, 32'h5A00_0000};
    cmds[1] = '{0, 32'hC004_203C, 32'h5A00_000F};
    cmd(0);
    cmd(1);
    hw(10'h03C, 1);
    hw(10'h024, 2);
    hr(10'h314);
    chk("wr two", v, 32'h0000_0E01);
    hw(10'h314, 32'h4000_0000);
    hr(10'h314);
    chk("wr abort", v, 32'h0000_1001);
    // mid-run reset with a word queued and a core access in flight
    hw(10'h020, 32'h0000_0001);
    hw(10'h304, 32'hC004_2000);
    @(negedge mclk_in);
    chk("run req", 32'(core_req_out), 1);
    rst_n_in = 1'b0;
    @(negedge mclk_in);
    chk("rst req", 32'(core_req_out), 0);
    rst_n_in = 1'b1;
    hr(10'h304);
    chk("rst cmd", v, 0);
    hr(10'h314);
    chk("rst space", v, 32'h0000_1001);
    close_out();
  end
endmodule : test_indirect_core_access_engine
